// >>> ccx_exec.sv
// Execution unit for calls, complements, compare-and-skip and bit xor.
// Assumes core state inputs are held steady while busy, and an
// asynchronous-read nibble data memory on the same clock.
//
// Overview of operation
// - Bit xor address is H then low nibble
// - Long call: three bytes, four cycles, PC+3
// - Long call pushes six nibbles below SP
// - Bank enable bits share one pushed nibble
// - Long target from second and third bytes
// - Long call loads target into PC
// - Short call: two bytes, three cycles, PC+2
// - Short call clears PC above eleven bits
// - Short call pushes only PC bits 10-0
// - Carry invert flips carry in one cycle
// - Accumulator complement inverts all four bits
// - Compare subtracts, skips next when equal
// - Compare forms and their base cycle counts
// - Pair against memory checks two nibbles
`timescale 1ns/100ps
module ccx_exec (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Instruction from fetch
	input wire logic instrStart,
	input wire logic [7:0] instrByte0,
	input wire logic [7:0] instrByte1,
	input wire logic [7:0] instrByte2,
	input wire logic [1:0] skippedCycles,
	// Core state
	input wire logic [13:0] pcIn,
	input wire logic [7:0] spIn,
	input wire logic carryIn,
	input wire logic [3:0] accIn,
	input wire logic [3:0] extIn,
	input wire logic [7:0] pointerPair,
	input wire logic [31:0] regFile,
	input wire logic memoryBankEnable,
	input wire logic registerBankEnable,
	// Data memory read
	output logic memRdEn,
	output logic [7:0] memRdAddr,
	input wire logic [3:0] memRdData,
	// Stack write
	output logic stkWe,
	output logic [7:0] stkAddr,
	output logic [7:0] stkData,
	// Results
	output logic busy,
	output logic execDone,
	output logic illegalOp,
	output logic pcLoad,
	output logic [13:0] pcValue,
	output logic spLoad,
	output logic [7:0] spValue,
	output logic carryLoad,
	output logic carryValue,
	output logic accLoad,
	output logic [3:0] accValue,
	output logic skipNext
);
	ccx_pkg::ccx_state_t state, next_state; // Sequencer state
	ccx_pkg::ccx_op_t op, next_op; // Operation in flight
	logic [7:0] b1, next_b1; // Held second byte
	logic [7:0] b2, next_b2; // Held third byte
	logic [13:0] pcHeld, next_pcHeld; // PC of the instruction
	logic [7:0] spHeld, next_spHeld; // SP at start
	logic [1:0] skipLen, next_skipLen; // Cycles of following instruction
	logic [2:0] step, next_step; // Cycle within execution
	logic [2:0] lastStep, next_lastStep; // Final step index
	logic eqLow, next_eqLow; // First nibble matched
	logic [2:0] shortHi, next_shortHi; // Short target bits 10-8
	logic next_busy, next_execDone, next_illegalOp;
	logic next_pcLoad, next_spLoad, next_carryLoad, next_accLoad, next_skipNext;
	logic [13:0] next_pcValue;
	logic [7:0] next_spValue;
	logic next_carryValue;
	logic [3:0] next_accValue;
	logic next_memRdEn;
	logic [7:0] next_memRdAddr;
	ccx_pkg::ccx_op_t startOp; // Decode of incoming bytes
	logic accept; // Instruction taken this cycle
	logic pushGo; // Start of stack frame
	logic [13:0] pushPc; // PC feeding the frame
	logic [7:0] frameHigh, frameMid, frameLow;
	logic [7:0] cmpLhs, cmpRhs; // Compare operands
	logic cmpWide;
	logic cmpEqual;
	logic evalNow; // Final compare this cycle
	logic extend; // Skip lengthens execution
	logic [2:0] effLast; // Last step after any skip

	// Nibble register by index
	function automatic logic [3:0] regNib(input logic [31:0] rf, input logic [2:0] idx);
		regNib = rf[{idx, 2'b00} +: 4];
	endfunction : regNib

	// Operation decode
	function automatic ccx_pkg::ccx_op_t decodeOp(input logic [7:0] c0, input logic [7:0] c1);
		decodeOp = ccx_pkg::OP_NONE;
		if (c0 == ccx_pkg::OPC_CALL_LONG && c1[7:5] == ccx_pkg::OPC_CALL_LONG_B1)
			decodeOp = ccx_pkg::OP_CALL_LONG;
		else if (c0[7:3] == ccx_pkg::OPC_CALL_SHORT)
			decodeOp = ccx_pkg::OP_CALL_SHORT;
		else if (c0 == ccx_pkg::OPC_CARRY_INVERT)
			decodeOp = ccx_pkg::OP_CARRY_INVERT;
		else if (c0 == ccx_pkg::OPC_CP_REG_IMM && !c1[3])
			decodeOp = ccx_pkg::OP_CP_REG_IMM;
		else if (c0 == ccx_pkg::OPC_CP_ACC_MEM)
			decodeOp = ccx_pkg::OP_CP_ACC_MEM;
		else if (c0 == ccx_pkg::OPC_PREFIX_DD) begin
			if (c1 == ccx_pkg::OPC_COM_B1)
				decodeOp = ccx_pkg::OP_COM;
			else if (c1[7:4] == ccx_pkg::OPC_CP_HL_IMM_B1)
				decodeOp = ccx_pkg::OP_CP_HL_IMM;
			else if (c1[7:3] == ccx_pkg::OPC_CP_ACC_REG_B1)
				decodeOp = ccx_pkg::OP_CP_ACC_REG;
		end else if (c0 == ccx_pkg::OPC_PREFIX_DC) begin
			if (c1 == ccx_pkg::OPC_CP_PAIR_MEM_B1)
				decodeOp = ccx_pkg::OP_CP_PAIR_MEM;
			else if (c1[7:3] == ccx_pkg::OPC_CP_PAIR_REG_B1 && !c1[0])
				decodeOp = ccx_pkg::OP_CP_PAIR_REG;
		end else if (c0 == ccx_pkg::OPC_BIT_XOR && c1[7:6] == ccx_pkg::OPC_BIT_XOR_HDA)
			decodeOp = ccx_pkg::OP_BIT_XOR;
	endfunction : decodeOp

	// Base cycle count of an operation
	function automatic logic [2:0] baseCycles(input ccx_pkg::ccx_op_t o);
		unique case (o)
			ccx_pkg::OP_CALL_LONG: baseCycles = ccx_pkg::CYC_CALL_LONG;
			ccx_pkg::OP_CALL_SHORT: baseCycles = ccx_pkg::CYC_CALL_SHORT;
			ccx_pkg::OP_CARRY_INVERT: baseCycles = ccx_pkg::CYC_CARRY_INVERT;
			ccx_pkg::OP_COM: baseCycles = ccx_pkg::CYC_COM;
			ccx_pkg::OP_CP_ACC_MEM: baseCycles = ccx_pkg::CYC_CP_ONE_BYTE;
			ccx_pkg::OP_BIT_XOR: baseCycles = ccx_pkg::CYC_BIT_XOR;
			ccx_pkg::OP_NONE: baseCycles = ccx_pkg::CYC_CP_ONE_BYTE;
			default: baseCycles = ccx_pkg::CYC_CP_TWO_BYTE;
		endcase
	endfunction : baseCycles

	assign startOp = decodeOp(instrByte0, instrByte1);
	assign accept = instrStart && (state == ccx_pkg::ST_IDLE);

	// Frame content; short call starts its frame at acceptance
	always_comb begin
		pushPc = (state == ccx_pkg::ST_IDLE) ? pcIn : pcHeld;
		pushGo = 1'b0;
		frameHigh = 8'h00;
		frameMid = 8'h00;
		frameLow = 8'h00;
		if (accept && startOp == ccx_pkg::OP_CALL_SHORT) begin
			pushGo = 1'b1;
			pushPc = pcIn + ccx_pkg::RET_INC_SHORT;
			frameLow = {5'h00, pushPc[10:8]};
		end else if (state == ccx_pkg::ST_RUN && op == ccx_pkg::OP_CALL_LONG && step == 3'h0) begin
			pushGo = 1'b1;
			pushPc = pcHeld + ccx_pkg::RET_INC_LONG;
			// PC bits 12-8, upper bits zero
			frameLow = {3'h0, pushPc[12:8]};
		end
		// bank enables in low two bits
		frameHigh = {6'h00, memoryBankEnable, registerBankEnable};
		frameMid = pushPc[7:0];
	end

	ccx_stack_push u_push (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.go(pushGo),
		.stackPtr((state == ccx_pkg::ST_IDLE) ? spIn : spHeld),
		.byteHigh(frameHigh),
		.byteMid(frameMid),
		.byteLow(frameLow),
		.stkWe(stkWe),
		.stkAddr(stkAddr),
		.stkData(stkData)
	);

	// Compare operand selection
	always_comb begin
		cmpLhs = 8'h00;
		cmpRhs = 8'h00;
		cmpWide = 1'b0;
		evalNow = 1'b0;
		if (state == ccx_pkg::ST_RUN) begin
			unique case (op)
				ccx_pkg::OP_CP_REG_IMM: begin
					cmpLhs = {4'h0, regNib(regFile, b1[2:0])};
					cmpRhs = {4'h0, b1[7:4]};
					evalNow = (step == 3'h0);
				end
				ccx_pkg::OP_CP_HL_IMM: begin
					cmpLhs = {4'h0, memRdData};
					cmpRhs = {4'h0, b1[3:0]};
					evalNow = (step == 3'h0);
				end
				ccx_pkg::OP_CP_ACC_REG: begin
					cmpLhs = {4'h0, accIn};
					cmpRhs = {4'h0, regNib(regFile, b1[2:0])};
					evalNow = (step == 3'h0);
				end
				ccx_pkg::OP_CP_ACC_MEM: begin
					cmpLhs = {4'h0, accIn};
					cmpRhs = {4'h0, memRdData};
					evalNow = (step == 3'h0);
				end
				// A against (HL), then E against (HL+1)
				ccx_pkg::OP_CP_PAIR_MEM: begin
					cmpLhs = {4'h0, (step == 3'h0) ? accIn : extIn};
					cmpRhs = {4'h0, memRdData};
					evalNow = (step == 3'h1);
				end
				ccx_pkg::OP_CP_PAIR_REG: begin
					cmpLhs = {extIn, accIn};
					cmpRhs = {regNib(regFile, {b1[2:1], 1'b1}), regNib(regFile, {b1[2:1], 1'b0})};
					cmpWide = 1'b1;
					evalNow = (step == 3'h0);
				end
				default: begin
					cmpLhs = 8'h00;
				end
			endcase
		end
	end

	ccx_compare u_cmp (
		.lhs(cmpLhs),
		.rhs(cmpRhs),
		.wide(cmpWide),
		.equal(cmpEqual)
	);

	always_comb begin
		extend = evalNow && cmpEqual && (op != ccx_pkg::OP_CP_PAIR_MEM || eqLow);
		effLast = extend ? (lastStep + {1'b0, skipLen}) : lastStep;
	end

	// Sequencer and result next values
	always_comb begin
		next_state = state;
		next_op = op;
		next_b1 = b1;
		next_b2 = b2;
		next_pcHeld = pcHeld;
		next_spHeld = spHeld;
		next_skipLen = skipLen;
		next_step = step;
		next_lastStep = lastStep;
		next_eqLow = eqLow;
		next_busy = busy;
		next_execDone = 1'b0;
		next_illegalOp = 1'b0;
		next_pcLoad = 1'b0;
		next_spLoad = 1'b0;
		next_carryLoad = 1'b0;
		next_accLoad = 1'b0;
		next_skipNext = skipNext;
		next_pcValue = pcValue;
		next_spValue = spValue;
		next_carryValue = carryValue;
		next_accValue = accValue;
		next_memRdEn = 1'b0;
		next_memRdAddr = memRdAddr;
		unique case (state)
			ccx_pkg::ST_IDLE: begin
				if (accept) begin
					next_state = ccx_pkg::ST_RUN;
					next_busy = 1'b1;
					next_op = startOp;
					next_b1 = instrByte1;
					next_b2 = instrByte2;
					next_pcHeld = pcIn;
					next_spHeld = spIn;
					next_skipLen = skippedCycles;
					next_step = 3'h0;
					next_lastStep = baseCycles(startOp) - 3'h1;
					next_eqLow = 1'b0;
					next_skipNext = 1'b0;
					// Memory operand read in the first cycle
					if (startOp == ccx_pkg::OP_CP_HL_IMM || startOp == ccx_pkg::OP_CP_ACC_MEM
						|| startOp == ccx_pkg::OP_CP_PAIR_MEM) begin
						next_memRdEn = 1'b1;
						next_memRdAddr = pointerPair;
					end else if (startOp == ccx_pkg::OP_BIT_XOR) begin
						next_memRdEn = 1'b1;
						next_memRdAddr = {pointerPair[7:4], instrByte1[3:0]};
					end
				end
			end
			ccx_pkg::ST_RUN: begin
				next_step = step + 3'h1;
				next_lastStep = effLast;
				if (op == ccx_pkg::OP_CP_PAIR_MEM && step == 3'h0) begin
					next_eqLow = cmpEqual;
					next_memRdEn = 1'b1;
					next_memRdAddr = memRdAddr + 8'h01;
				end
				if (extend)
					next_skipNext = 1'b1;
				if (op == ccx_pkg::OP_BIT_XOR && step == 3'h0)
					next_carryValue = carryIn ^ memRdData[b1[5:4]];
				if (step == effLast) begin
					next_state = ccx_pkg::ST_IDLE;
					next_busy = 1'b0;
					next_execDone = 1'b1;
					next_illegalOp = (op == ccx_pkg::OP_NONE);
					unique case (op)
						ccx_pkg::OP_CALL_LONG: begin
							next_pcLoad = 1'b1;
							next_pcValue = {1'b0, b1[4:0], b2};
							next_spLoad = 1'b1;
							next_spValue = spHeld - ccx_pkg::STACK_FRAME;
						end
						ccx_pkg::OP_CALL_SHORT: begin
							next_pcLoad = 1'b1;
							next_pcValue = {3'h0, shortHi, b1};
							next_spLoad = 1'b1;
							next_spValue = spHeld - ccx_pkg::STACK_FRAME;
						end
						ccx_pkg::OP_CARRY_INVERT: begin
							next_carryLoad = 1'b1;
							next_carryValue = ~carryIn;
						end
						ccx_pkg::OP_COM: begin
							next_accLoad = 1'b1;
							next_accValue = ~accIn;
						end
						ccx_pkg::OP_BIT_XOR: begin
							next_carryLoad = 1'b1;
						end
						default: begin
							next_pcLoad = 1'b0;
						end
					endcase
				end
			end
		endcase
	end

	// First-byte address bits captured at acceptance
	always_comb begin
		next_shortHi = shortHi;
		if (accept)
			next_shortHi = instrByte0[2:0];
	end

	// Registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ccx_pkg::ST_IDLE;
			op <= ccx_pkg::OP_NONE;
			b1 <= 8'h00;
			b2 <= 8'h00;
			pcHeld <= 14'h0000;
			spHeld <= 8'h00;
			skipLen <= 2'h0;
			step <= 3'h0;
			lastStep <= 3'h0;
			eqLow <= 1'b0;
			shortHi <= 3'h0;
			busy <= 1'b0;
			execDone <= 1'b0;
			illegalOp <= 1'b0;
			pcLoad <= 1'b0;
			pcValue <= 14'h0000;
			spLoad <= 1'b0;
			spValue <= 8'h00;
			carryLoad <= 1'b0;
			carryValue <= 1'b0;
			accLoad <= 1'b0;
			accValue <= 4'h0;
			skipNext <= 1'b0;
			memRdEn <= 1'b0;
			memRdAddr <= 8'h00;
		end else begin
			state <= next_state;
			op <= next_op;
			b1 <= next_b1;
			b2 <= next_b2;
			pcHeld <= next_pcHeld;
			spHeld <= next_spHeld;
			skipLen <= next_skipLen;
			step <= next_step;
			lastStep <= next_lastStep;
			eqLow <= next_eqLow;
			shortHi <= next_shortHi;
			busy <= next_busy;
			execDone <= next_execDone;
			illegalOp <= next_illegalOp;
			pcLoad <= next_pcLoad;
			pcValue <= next_pcValue;
			spLoad <= next_spLoad;
			spValue <= next_spValue;
			carryLoad <= next_carryLoad;
			carryValue <= next_carryValue;
			accLoad <= next_accLoad;
			accValue <= next_accValue;
			skipNext <= next_skipNext;
			memRdEn <= next_memRdEn;
			memRdAddr <= next_memRdAddr;
		end
	end
endmodule : ccx_exec

// >>> ccx_pkg.sv
// Constants shared by the call, compare and complement execution unit.
// Assumes one core clock; this file holds no logic.
package ccx_pkg;

	// Opcode bytes and fields
	localparam logic [7:0] OPC_CALL_LONG = 8'hdb; // Long call, first byte
	localparam logic [2:0] OPC_CALL_LONG_B1 = 3'h2; // Fixed top bits of second byte
	localparam logic [4:0] OPC_CALL_SHORT = 5'h1d; // Short call, top five bits
	localparam logic [7:0] OPC_CARRY_INVERT = 8'hd6; // Carry complement
	localparam logic [7:0] OPC_PREFIX_DD = 8'hdd; // Complement, compare prefix
	localparam logic [7:0] OPC_COM_B1 = 8'h3f; // Accumulator complement, second byte
	localparam logic [7:0] OPC_CP_REG_IMM = 8'hd9; // Register against immediate
	localparam logic [3:0] OPC_CP_HL_IMM_B1 = 4'h7; // Memory against immediate
	localparam logic [4:0] OPC_CP_ACC_REG_B1 = 5'h0d; // Accumulator against register
	localparam logic [7:0] OPC_CP_ACC_MEM = 8'h38; // Accumulator against memory
	localparam logic [7:0] OPC_PREFIX_DC = 8'hdc; // Pair compare prefix
	localparam logic [7:0] OPC_CP_PAIR_MEM_B1 = 8'h09; // Pair against memory
	localparam logic [4:0] OPC_CP_PAIR_REG_B1 = 5'h1d; // Pair against register pair
	localparam logic [7:0] OPC_BIT_XOR = 8'hf7; // Bit exclusive-or prefix
	localparam logic [1:0] OPC_BIT_XOR_HDA = 2'h0; // H plus direct address form

	// Cycle counts and pointer arithmetic
	localparam logic [2:0] CYC_CALL_LONG = 3'h4;
	localparam logic [2:0] CYC_CALL_SHORT = 3'h3;
	localparam logic [2:0] CYC_CARRY_INVERT = 3'h1;
	localparam logic [2:0] CYC_COM = 3'h2;
	localparam logic [2:0] CYC_CP_TWO_BYTE = 3'h2;
	localparam logic [2:0] CYC_CP_ONE_BYTE = 3'h1;
	localparam logic [2:0] CYC_BIT_XOR = 3'h2;
	localparam logic [13:0] RET_INC_LONG = 14'h0003;
	localparam logic [13:0] RET_INC_SHORT = 14'h0002;
	localparam logic [7:0] STACK_FRAME = 8'h06;
	localparam logic [7:0] STACK_STEP = 8'h02;

	// Executed operations
	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_CALL_LONG = 4'b0001,
		OP_CALL_SHORT = 4'b0010,
		OP_CARRY_INVERT = 4'b0011,
		OP_COM = 4'b0100,
		OP_CP_REG_IMM = 4'b0101,
		OP_CP_HL_IMM = 4'b0110,
		OP_CP_ACC_REG = 4'b0111,
		OP_CP_ACC_MEM = 4'b1000,
		OP_CP_PAIR_MEM = 4'b1001,
		OP_CP_PAIR_REG = 4'b1010,
		OP_BIT_XOR = 4'b1011
	} ccx_op_t;

	// Sequencer states
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} ccx_state_t;

endpackage : ccx_pkg

// >>> ccx_compare.sv
// Equality by subtraction for compare-and-skip.
// Assumes operands are stable same-clock values.
`timescale 1ns/100ps
module ccx_compare (
	// Operands
	input wire logic [7:0] lhs,
	input wire logic [7:0] rhs,
	input wire logic wide,
	// Result
	output logic equal
);
	logic [7:0] diff; // Destination minus source

	// Difference, upper nibble ignored for nibble compares
	always_comb begin
		diff = lhs - rhs;
		equal = wide ? (diff == 8'h00) : (diff[3:0] == 4'h0);
	end
endmodule : ccx_compare

// >>> ccx_stack_push.sv
// Writes a three-byte call frame below the stack pointer.
// Assumes a byte-wide stack port: high nibble at addr+1, low at addr.
`timescale 1ns/100ps
module ccx_stack_push (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Frame request
	input wire logic go,
	input wire logic [7:0] stackPtr,
	input wire logic [7:0] byteHigh,
	input wire logic [7:0] byteMid,
	input wire logic [7:0] byteLow,
	// Stack write port
	output logic stkWe,
	output logic [7:0] stkAddr,
	output logic [7:0] stkData
);
	logic [1:0] left; // Writes still to issue after this one
	logic [1:0] next_left;
	logic [7:0] midByte; // Held return address low byte
	logic [7:0] lowByte; // Held return address high part
	logic [7:0] next_midByte;
	logic [7:0] next_lowByte;
	logic next_stkWe;
	logic [7:0] next_stkAddr;
	logic [7:0] next_stkData;

	// One write per cycle, pointer walking down by two nibbles
	always_comb begin
		next_left = left;
		next_midByte = midByte;
		next_lowByte = lowByte;
		next_stkWe = 1'b0;
		next_stkAddr = stkAddr;
		next_stkData = stkData;
		if (go) begin
			// Bank enables at SP-1/SP-2
			next_stkWe = 1'b1;
			next_stkAddr = stackPtr - ccx_pkg::STACK_STEP;
			next_stkData = byteHigh;
			next_midByte = byteMid;
			next_lowByte = byteLow;
			next_left = 2'h2;
		end else if (left != 2'h0) begin
			// Return address at SP-3/SP-4 then SP-5/SP-6
			next_stkWe = 1'b1;
			next_stkAddr = stkAddr - ccx_pkg::STACK_STEP;
			next_stkData = (left == 2'h2) ? midByte : lowByte;
			next_left = left - 2'h1;
		end
	end

	// Registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			left <= 2'h0;
			midByte <= 8'h00;
			lowByte <= 8'h00;
			stkWe <= 1'b0;
			stkAddr <= 8'h00;
			stkData <= 8'h00;
		end else begin
			left <= next_left;
			midByte <= next_midByte;
			lowByte <= next_lowByte;
			stkWe <= next_stkWe;
			stkAddr <= next_stkAddr;
			stkData <= next_stkData;
		end
	end
endmodule : ccx_stack_push

// >>> ccx_exec_fix.sv
// Holds no logic; the unit's modules live in their own files.

// >>> ccx_exec_sva.sv
// Concurrent checks on the call, compare and complement unit.
// Assumes it is bound to the unit's top module, one clock domain.
`timescale 1ns/100ps
module ccx_exec_sva (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Request
	input wire logic instrStart,
	input wire logic [7:0] instrByte0,
	input wire logic [7:0] instrByte1,
	input wire logic carryIn,
	input wire logic [3:0] accIn,
	input wire logic [7:0] pointerPair,
	// Results
	input wire logic busy,
	input wire logic execDone,
	input wire logic pcLoad,
	input wire logic [13:0] pcValue,
	input wire logic carryLoad,
	input wire logic carryValue,
	input wire logic accLoad,
	input wire logic [3:0] accValue,
	input wire logic memRdEn,
	input wire logic [7:0] memRdAddr,
	input wire logic stkWe,
	input wire logic [7:0] stkAddr
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Request taken at this edge
	wire logic take = instrStart && !busy;

	property p_done;
		execDone |-> ($past(busy) && !busy) ##1 !execDone;
	endproperty
	a_done: assert property (p_done) else $error("done pulse misplaced");
	property p_long;
		take && instrByte0 == ccx_pkg::OPC_CALL_LONG |=> busy [*4] ##1 (execDone && pcLoad && !busy);
	endproperty
	a_long: assert property (p_long) else $error("long call timing wrong");
	property p_long_push;
		take && instrByte0 == ccx_pkg::OPC_CALL_LONG |=> !stkWe ##1 stkWe [*3] ##1 !stkWe;
	endproperty
	a_long_push: assert property (p_long_push) else $error("long call push count wrong");
	property p_short;
		take && instrByte0[7:3] == ccx_pkg::OPC_CALL_SHORT |=> stkWe [*3] ##1
			(execDone && pcLoad && pcValue == {3'h0, $past(instrByte0[2:0], 4), $past(instrByte1, 4)});
	endproperty
	a_short: assert property (p_short) else $error("short call target wrong");
	property p_carry;
		take && instrByte0 == ccx_pkg::OPC_CARRY_INVERT |=> busy ##1 (carryLoad && carryValue == !$past(carryIn, 2));
	endproperty
	a_carry: assert property (p_carry) else $error("carry invert wrong");
	property p_com;
		take && instrByte0 == ccx_pkg::OPC_PREFIX_DD && instrByte1 == ccx_pkg::OPC_COM_B1 |=>
			busy [*2] ##1 (accLoad && accValue == ~$past(accIn, 3));
	endproperty
	a_com: assert property (p_com) else $error("complement wrong");
	property p_bit_exclusive_or_op;
		take && instrByte0 == ccx_pkg::OPC_BIT_XOR && instrByte1[7:6] == ccx_pkg::OPC_BIT_XOR_HDA |=>
			memRdEn && memRdAddr == {$past(pointerPair[7:4]), $past(instrByte1[3:0])};
	endproperty
	a_bit_exclusive_or_op: assert property (p_bit_exclusive_or_op) else $error("bit xor address wrong");
	property p_pair_mem;
		take && instrByte0 == ccx_pkg::OPC_PREFIX_DC && instrByte1 == ccx_pkg::OPC_CP_PAIR_MEM_B1 |=>
			memRdAddr == $past(pointerPair) ##1 memRdAddr == $past(pointerPair, 2) + 8'h01;
	endproperty
	a_pair_mem: assert property (p_pair_mem) else $error("pair compare reads wrong");
	property p_stk_even;
		stkWe |-> busy && !stkAddr[0];
	endproperty
	a_stk_even: assert property (p_stk_even) else $error("stack write misplaced");
endmodule : ccx_exec_sva

bind ccx_exec ccx_exec_sva u_ccx_exec_sva (.core_clk(core_clk), .rst_n(rst_n), .instrStart(instrStart),
	.instrByte0(instrByte0), .instrByte1(instrByte1), .carryIn(carryIn), .accIn(accIn),
	.pointerPair(pointerPair), .busy(busy), .execDone(execDone), .pcLoad(pcLoad), .pcValue(pcValue),
	.carryLoad(carryLoad), .carryValue(carryValue), .accLoad(accLoad), .accValue(accValue),
	.memRdEn(memRdEn), .memRdAddr(memRdAddr), .stkWe(stkWe), .stkAddr(stkAddr));

// >>> ccx_data_mem.sv
// Nibble data memory model behind the unit, holding the stack.
// Assumes byte stack writes: high nibble to the odd address.
`timescale 1ns/100ps
module ccx_data_mem (
	// Clock
	input wire logic core_clk,
	// Read port
	input wire logic memRdEn,
	input wire logic [7:0] memRdAddr,
	output logic [3:0] memRdData,
	// Stack write port
	input wire logic stkWe,
	input wire logic [7:0] stkAddr,
	input wire logic [7:0] stkData
);
	logic [3:0] mem [0:255]; // Nibble storage
	logic [3:0] lastRd = 4'h0; // Last value read
	// Unselected port shows the inverse of the last read
	assign memRdData = memRdEn ? mem[memRdAddr] : ~lastRd;
	// Byte writes and read tracking
	always @(posedge core_clk) begin
		if (memRdEn) begin
			lastRd <= mem[memRdAddr];
		end
		if (stkWe) begin
			mem[stkAddr + 8'h01] <= stkData[7:4];
			mem[stkAddr] <= stkData[3:0];
		end
	end
endmodule : ccx_data_mem

// >>> tb_call_compare_complement_exec.sv
// Self-checking bench for the call, compare and complement unit.
// Assumes the data memory model answers reads in the same cycle.
`timescale 1ns/100ps
module tb_call_compare_complement_exec;
	typedef struct packed {logic [7:0] b0; logic [7:0] b1; logic [7:0] ptr; logic [1:0] base; logic eq;} ccx_case_t;
	logic core_clk = 1'b0, rst_n = 1'b0, instrStart = 1'b0, carryIn = 1'b0;
	logic [7:0] instrByte0 = 8'h00, instrByte1 = 8'h00, instrByte2 = 8'h00, spIn = 8'h00, pointerPair = 8'h00;
	logic [1:0] skippedCycles = 2'h0;
	logic [13:0] pcIn = 14'h0000;
	logic [3:0] accIn = 4'h0, extIn = 4'h0, memRdData;
	logic [31:0] regFile = 32'h75543210; // Register r holds r, except r6 = 5
	logic memoryBankEnable = 1'b0, registerBankEnable = 1'b0;
	logic memRdEn, stkWe, busy, execDone, illegalOp, pcLoad, spLoad, carryLoad, carryValue, accLoad, skipNext;
	logic [7:0] memRdAddr, stkAddr, stkData, spValue;
	logic [13:0] pcValue;
	logic [3:0] accValue;
	int n_fail = 0, cmp_count = 0, ticks = 0;

	ccx_exec u_ccx_exec (.core_clk(core_clk), .rst_n(rst_n), .instrStart(instrStart), .instrByte0(instrByte0),
		.instrByte1(instrByte1), .instrByte2(instrByte2), .skippedCycles(skippedCycles), .pcIn(pcIn),
		.spIn(spIn), .carryIn(carryIn), .accIn(accIn), .extIn(extIn), .pointerPair(pointerPair),
		.regFile(regFile), .memoryBankEnable(memoryBankEnable), .registerBankEnable(registerBankEnable),
		.memRdEn(memRdEn), .memRdAddr(memRdAddr), .memRdData(memRdData), .stkWe(stkWe), .stkAddr(stkAddr),
		.stkData(stkData), .busy(busy), .execDone(execDone), .illegalOp(illegalOp), .pcLoad(pcLoad),
		.pcValue(pcValue), .spLoad(spLoad), .spValue(spValue), .carryLoad(carryLoad),
		.carryValue(carryValue), .accLoad(accLoad), .accValue(accValue), .skipNext(skipNext));
	ccx_data_mem u_ccx_data_mem (.core_clk(core_clk), .memRdEn(memRdEn), .memRdAddr(memRdAddr),
		.memRdData(memRdData), .stkWe(stkWe), .stkAddr(stkAddr), .stkData(stkData));

	// Clock and hang guard
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		ticks++;
		if (ticks == 3000) begin
			n_fail++;
			conclude();
		end
	end

	// Offer one instruction, count cycles up to its done pulse
	task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic [1:0] s, output int cyc);
		instrByte0 = b0;
		instrByte1 = b1;
		skippedCycles = s;
		instrStart = 1'b1;
		@(posedge core_clk);
		#1;
		instrStart = 1'b0;
		cyc = 0;
		while (execDone !== 1'b1 && cyc < 20) begin
			@(posedge core_clk);
			#1;
			cyc++;
		end
	endtask : issue

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chkCyc(input string what, input int exp, input int got);
		cmp_count++;
		if (got != exp) begin
			n_fail++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chkCyc

	// Stack nibbles 0fa..0ff against packed expectation, 0fa lowest
	task automatic chkStack(input logic [23:0] exp);
		for (int i = 0; i < 6; i++) begin
			chk("stack nibble", {12'h000, exp[4*i+:4]}, {12'h000, u_ccx_data_mem.mem[8'hfa + 8'(i)]});
		end
	endtask : chkStack

	// Call state; stack area filled with ones to expose unwritten zeros
	task automatic callSetup(input logic [13:0] pc, input logic memory_bank_enable, input logic register_bank_enable);
		pcIn = pc;
		spIn = 8'h00;
		memoryBankEnable = memory_bank_enable;
		registerBankEnable = register_bank_enable;
		for (int i = 250; i < 256; i++) begin
			u_ccx_data_mem.mem[i] = 4'hf;
		end
	endtask : callSetup

	task automatic t_long();
		int cyc;
		callSetup(14'h0123, 1'b1, 1'b0);
		instrByte2 = 8'h3f;
		issue(ccx_pkg::OPC_CALL_LONG, 8'h5e, 2'd0, cyc);
		chkCyc("long cycles", 4, cyc);
		chk("long pc", {2'b11, 14'h1e3f}, {pcLoad, spLoad, pcValue});
		chk("long sp", 16'h00fa, {8'h00, spValue});
		chkStack(24'h022601);
		$display("test long call done");
	endtask : t_long

	task automatic t_short();
		int cyc;
		callSetup(14'h3f23, 1'b0, 1'b1);
		issue({ccx_pkg::OPC_CALL_SHORT, 3'h3}, 8'h45, 2'd0, cyc);
		chkCyc("short cycles", 3, cyc);
		chk("short pc", {2'b11, 14'h0345}, {pcLoad, spLoad, pcValue});
		chk("short sp", 16'h00fa, {8'h00, spValue});
		chkStack(24'h012507);
		$display("test short call done");
	endtask : t_short

	task automatic t_flip();
		int cyc;
		for (int c = 0; c < 2; c++) begin
			carryIn = c[0];
			issue(ccx_pkg::OPC_CARRY_INVERT, 8'h00, 2'd0, cyc);
			chkCyc("carry cycles", 1, cyc);
			chk("carry", {15'h0001, ~c[0]}, {14'h0000, carryLoad, carryValue});
		end
		accIn = 4'h4;
		issue(ccx_pkg::OPC_PREFIX_DD, ccx_pkg::OPC_COM_B1, 2'd0, cyc);
		chkCyc("complement cycles", 2, cyc);
		chk("complement", 16'h001b, {11'h000, accLoad, accValue});
		issue(8'h00, 8'h00, 2'd0, cyc);
		chk("undecoded", 16'h0011, {11'h000, illegalOp, 1'b0, 3'(cyc)});
		$display("test complements done");
	endtask : t_flip

	// Every compare form, equal and unequal, with varied skip length
	task automatic t_cmp();
		ccx_case_t tbl [12] = '{'{8'hd9, 8'h33, 8'h20, 2'd2, 1'b1}, '{8'hd9, 8'h43, 8'h20, 2'd2, 1'b0},
			'{8'hdd, 8'h75, 8'h20, 2'd2, 1'b1}, '{8'hdd, 8'h74, 8'h20, 2'd2, 1'b0},
			'{8'hdd, 8'h6d, 8'h20, 2'd2, 1'b1}, '{8'hdd, 8'h6c, 8'h20, 2'd2, 1'b0},
			'{8'h38, 8'h00, 8'h20, 2'd1, 1'b1}, '{8'h38, 8'h00, 8'h30, 2'd1, 1'b0},
			'{8'hdc, 8'h09, 8'h20, 2'd2, 1'b1}, '{8'hdc, 8'h09, 8'h1f, 2'd2, 1'b0},
			'{8'hdc, 8'hee, 8'h20, 2'd2, 1'b1}, '{8'hdc, 8'hea, 8'h20, 2'd2, 1'b0}};
		int cyc;
		logic [1:0] s;
		accIn = 4'h5;
		extIn = 4'h7;
		u_ccx_data_mem.mem[8'h1f] = 4'h5;
		u_ccx_data_mem.mem[8'h20] = 4'h5;
		u_ccx_data_mem.mem[8'h21] = 4'h7;
		u_ccx_data_mem.mem[8'h30] = 4'h9;
		for (int i = 0; i < 12; i++) begin
			s = 2'(i % 3 + 1);
			pointerPair = tbl[i].ptr;
			issue(tbl[i].b0, tbl[i].b1, s, cyc);
			chkCyc("compare cycles", tbl[i].base + (tbl[i].eq ? s : 2'd0), cyc);
			chk("compare skip", {15'h0000, tbl[i].eq}, {13'h0000, accLoad, carryLoad, skipNext});
		end
		$display("test compares done");
	endtask : t_cmp

	task automatic t_bit_exclusive_or_op();
		int cyc;
		logic [3:0] pat = 4'ha;
		pointerPair = 8'h2b;
		carryIn = 1'b1;
		u_ccx_data_mem.mem[8'h20] = pat;
		for (int b = 0; b < 4; b++) begin
			issue(ccx_pkg::OPC_BIT_XOR, {2'b00, b[1:0], 4'h0}, 2'd0, cyc);
			chkCyc("bit xor cycles", 2, cyc);
			chk("bit xor carry", {15'h0001, ~pat[b]}, {14'h0000, carryLoad, carryValue});
		end
		$display("test bit xor done");
	endtask : t_bit_exclusive_or_op

	task automatic conclude();
		$display("counts: %0d comparisons, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	// Reset, then scenarios back to back
	initial begin
		repeat (6) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		t_long();
		t_short();
		t_flip();
		t_cmp();
		t_bit_exclusive_or_op();
		conclude();
	end
endmodule : tb_call_compare_complement_exec
